// File: logic/emdp_top.sv
/*
 * Ethernet MAC controller register window and DMA address/length engine,
 * plus the receive byte FIFO that sits between the wire and memory writes.
 * Assumes a one-cycle I/O strobe on a 9-bit address, a MAC core that
 * reports each transmit attempt and streams received bytes, and memory
 * ports with request/acknowledge handshakes. One clock, async reset.
 */
`timescale 1ns/10ps
`default_nettype none

module emdp_fifo #(
   parameter int unsigned WIDTH = 8,
   parameter int unsigned DEPTH = 32
) (
   // Clock and reset
   input  wire logic             clk_i,
   input  wire logic             nrst_i,
   // Fill side
   input  wire logic             in_valid_i,
   output logic                  in_ready_o,
   input  wire logic [WIDTH-1:0] in_data_i,
   // Drain side
   output logic                  out_valid_o,
   input  wire logic             out_ready_i,
   output logic [WIDTH-1:0]      out_data_o
);
   localparam int unsigned PW = $clog2(DEPTH);

   typedef struct packed {
      logic [DEPTH-1:0][WIDTH-1:0] mem;
      logic [PW:0]                 wr;
      logic [PW:0]                 rd;
   } emdp_fifo_st_t;

   emdp_fifo_st_t st_ff;
   emdp_fifo_st_t nxt_st;
   logic          full;
   logic          empty;

   assign empty       = (st_ff.wr == st_ff.rd);
   assign full        = (st_ff.wr[PW-1:0] == st_ff.rd[PW-1:0]) && !empty;
   assign in_ready_o  = !full;
   assign out_valid_o = !empty;
   assign out_data_o  = st_ff.mem[st_ff.rd[PW-1:0]];

   always_comb begin
      nxt_st = st_ff;
      if (in_valid_i && !full) begin
         nxt_st.mem[st_ff.wr[PW-1:0]] = in_data_i;
         nxt_st.wr                    = st_ff.wr + 1'b1;
      end
      if (out_ready_i && !empty) begin
         nxt_st.rd = st_ff.rd + 1'b1;
      end
   end

   always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         st_ff <= '0;
      end else begin
         st_ff <= nxt_st;
      end
   end
endmodule : emdp_fifo

module emdp_top (
   // Clock and reset
   input  wire logic          clk_i,
   input  wire logic          nrst_i,
   // I/O register access
   input  wire logic          io_req_i,
   input  wire logic          io_we_i,
   input  wire logic [8:0]    io_addr_i,
   input  wire logic [31:0]   io_wdata_i,
   output logic               io_ack_o,
   output logic [31:0]        io_rdata_o,
   // Adaptor control levels
   input  wire logic          tx_enable_i,
   input  wire logic          rx_enable_i,
   // Transmit attempt report from the MAC
   input  wire logic          tx_attempt_done_i,
   input  wire logic          tx_collision_i,
   input  wire logic          tx_excess_collision_i,
   input  wire logic          tx_underflow_i,
   // Transmit memory read requests
   output logic               tx_rd_req_o,
   output logic [31:0]        tx_rd_addr_o,
   input  wire logic          tx_rd_ack_i,
   // Received byte stream from the MAC
   input  wire logic          rx_byte_valid_i,
   input  wire logic [7:0]    rx_byte_i,
   input  wire logic          rx_frame_end_i,
   input  wire logic          rx_checksum_fail_i,
   input  wire logic          rx_odd_bit_tail_i,
   // Receive memory writes
   output logic               mem_wr_valid_o,
   output logic [31:0]        mem_wr_addr_o,
   output logic [7:0]         mem_wr_data_o,
   input  wire logic          mem_wr_ready_i,
   // MAC interrupts and board status copies
   output logic               tx_irq_o,
   output logic               rx_irq_o,
   output logic [7:0]         send_result_copy_o,
   output logic [7:0]         receive_result_copy_o,
   // Descriptor queue state
   output logic [3:0]         descriptor_consume_ptr_o,
   output logic [3:0]         descriptor_produce_ptr_o,
   output logic               desc_empty_o,
   output logic               desc_full_o
);
   import emdp_pkg::*;

   typedef enum logic [1:0] {TX_IDLE, TX_RUN, TX_WAIT} emdp_tx_state_t;
   typedef enum logic [2:0] {RX_IDLE, RX_READY, RX_FRAME, RX_DRAIN, RX_HALT} emdp_rx_state_t;

   typedef struct packed {
      logic [5:0][7:0]              station_address_bytes;
      logic [7:0]                   receive_mask_reg;
      logic [3:0]                   send_mask_reg;
      logic [3:0]                   send_result_reg;
      logic [5:0]                   receive_result_reg;
      logic [29:0]                  send_buffer_base;
      logic [15:0]                  send_buffer_size;
      logic [31:0]                  tx_addr_cnt;
      logic [15:0]                  tx_len_cnt;
      logic [DESC_DEPTH-1:0][29:0]  dq_base;
      logic [DESC_DEPTH-1:0][11:0]  dq_size;
      logic [3:0]                   descriptor_produce_ptr;
      logic [3:0]                   descriptor_consume_ptr;
      logic [31:0]                  rx_addr_cnt;
      logic [15:0]                  rx_len_cnt;
      emdp_tx_state_t               txs;
      emdp_rx_state_t               rxs;
      logic [5:0][7:0]              dst;
      logic [15:0]                  nbytes;
      logic                         ovf;
      logic                         rx_keep;
      logic                         rx_stop;
      logic                         rx_notify;
      logic                         io_ack;
      logic [31:0]                  io_rdata;
      logic                         tx_rd_req;
      logic                         mem_wr_valid;
      logic [31:0]                  mem_wr_addr;
      logic [7:0]                   mem_wr_data;
      logic                         tx_irq;
      logic                         rx_irq;
      logic [7:0]                   send_copy;
      logic [7:0]                   recv_copy;
      logic                         desc_empty;
      logic                         desc_full;
   } emdp_st_t;

   emdp_st_t   st_ff;
   emdp_st_t   nxt_st;
   logic       fifo_in_valid;
   logic       fifo_in_ready;
   logic       fifo_out_valid;
   logic       fifo_out_ready;
   logic [7:0] fifo_out_data;

   function automatic logic grp_hit(input logic [8:0] addr, input logic [2:0] grp);
      grp_hit = (addr[GRP_HI:GRP_LO] == grp);
   endfunction : grp_hit

   // Drain FIFO into the registered memory-write stage while a buffer is open
   assign fifo_out_ready = (st_ff.rxs != RX_IDLE) && (st_ff.rxs != RX_HALT) &&
                           (!st_ff.mem_wr_valid || mem_wr_ready_i);

   // Mode 0 keeps nothing, so nothing is pushed; overflow stops the push
   assign fifo_in_valid  = rx_byte_valid_i &&
                           ((st_ff.rxs == RX_READY) || ((st_ff.rxs == RX_FRAME) && !st_ff.ovf)) &&
                           (st_ff.receive_mask_reg[7:6] != FILT_NONE);

   emdp_fifo #(
      .WIDTH (FIFO_WIDTH),
      .DEPTH (FIFO_DEPTH)
   ) u_rx_fifo (
      .clk_i       (clk_i),
      .nrst_i      (nrst_i),
      .in_valid_i  (fifo_in_valid),
      .in_ready_o  (fifo_in_ready),
      .in_data_i   (rx_byte_i),
      .out_valid_o (fifo_out_valid),
      .out_ready_i (fifo_out_ready),
      .out_data_o  (fifo_out_data)
   );

   always_comb begin
      logic       mac_sel;
      logic       dma_sel;
      logic [2:0] mofs;
      logic [1:0] dofs;
      logic       status_rd;
      logic [2:0] tx_err;
      logic       accepted;
      logic       is_bcast;
      logic       is_station;
      logic       runt;
      logic [5:0] rres;
      logic [3:0] slot;
      mac_sel    = io_req_i && grp_hit(io_addr_i, GRP_MAC);
      dma_sel    = io_req_i && grp_hit(io_addr_i, GRP_DMA);
      mofs       = io_addr_i[2:0];
      dofs       = io_addr_i[1:0];
      status_rd  = 1'b0;
      tx_err     = {tx_excess_collision_i, tx_collision_i, tx_underflow_i};
      accepted   = 1'b0;
      is_bcast   = 1'b0;
      is_station = 1'b0;
      runt       = 1'b0;
      rres       = '0;
      slot       = st_ff.descriptor_consume_ptr;
      nxt_st     = st_ff;
      nxt_st.io_ack   = mac_sel || dma_sel;
      nxt_st.io_rdata = '0;

      // Register reads
      if (mac_sel && !io_we_i) begin
         if (mofs == OFS_RX_MASK) begin
            nxt_st.io_rdata = {26'h0, st_ff.receive_result_reg};
            nxt_st.rx_irq   = 1'b0;
            status_rd       = 1'b1;
         end else if (mofs == OFS_TX_MASK) begin
            nxt_st.io_rdata = {28'h0, st_ff.send_result_reg};
            nxt_st.tx_irq   = 1'b0;
            status_rd       = 1'b1;
         end
      end else if (dma_sel && !io_we_i) begin
         if (dofs == OFS_TX_BASE) begin
            nxt_st.io_rdata = st_ff.tx_addr_cnt;
         end else if (dofs == OFS_RX_BASE) begin
            nxt_st.io_rdata = st_ff.rx_addr_cnt;
         end
      end

      // Register writes
      if (mac_sel && io_we_i) begin
         if (mofs <= OFS_STATION_LAST) begin
            nxt_st.station_address_bytes[mofs] = io_wdata_i[7:0];
         end else if (mofs == OFS_RX_MASK) begin
            nxt_st.receive_mask_reg = io_wdata_i[7:0];
         end else begin
            nxt_st.send_mask_reg = io_wdata_i[3:0];
         end
      end else if (dma_sel && io_we_i) begin
         if (dofs == OFS_TX_BASE) begin
            nxt_st.send_buffer_base = io_wdata_i[31:2];
         end else if (dofs == OFS_TX_SIZE) begin
            nxt_st.send_buffer_size = io_wdata_i[15:0];
         end else if (dofs == OFS_RX_BASE) begin
            nxt_st.dq_base[st_ff.descriptor_produce_ptr] = io_wdata_i[31:2];
         end else if (!st_ff.desc_full) begin
            // A size written into a full queue is dropped so no slot is lost
            nxt_st.dq_size[st_ff.descriptor_produce_ptr] = io_wdata_i[15:4];
            nxt_st.descriptor_produce_ptr = st_ff.descriptor_produce_ptr + 4'h1;
         end
      end

      // Transmit engine
      case (st_ff.txs)
         TX_IDLE: begin
            if (tx_enable_i) begin
               nxt_st.tx_addr_cnt = {st_ff.send_buffer_base, 2'b00};
               nxt_st.tx_len_cnt  = st_ff.send_buffer_size;
               nxt_st.txs         = TX_RUN;
            end
         end
         TX_RUN: begin
            if (!tx_enable_i) begin
               nxt_st.txs = TX_IDLE;
            end else if (tx_attempt_done_i) begin
               nxt_st.send_result_reg = {(tx_err == 3'b000), tx_err};
               if ((tx_err & st_ff.send_mask_reg[2:0]) != 3'b000) begin
                  nxt_st.tx_irq = 1'b1;
                  nxt_st.txs    = TX_WAIT;
               end else if (tx_err != 3'b000) begin
                  // Unmasked error: rewind and resend, MAC does backoff
                  nxt_st.tx_addr_cnt = {st_ff.send_buffer_base, 2'b00};
                  nxt_st.tx_len_cnt  = st_ff.send_buffer_size;
               end else begin
                  nxt_st.tx_irq = st_ff.send_mask_reg[TX_GOOD_BIT];
                  nxt_st.txs    = TX_WAIT;
               end
            end else if (st_ff.tx_rd_req && tx_rd_ack_i) begin
               nxt_st.tx_addr_cnt = st_ff.tx_addr_cnt + 32'h4;
               nxt_st.tx_len_cnt  = (st_ff.tx_len_cnt > TX_WORD_BYTES) ?
                                    (st_ff.tx_len_cnt - TX_WORD_BYTES) : 16'h0;
            end
         end
         default: begin
            if (!tx_enable_i) begin
               nxt_st.txs = TX_IDLE;
            end
         end
      endcase
      nxt_st.tx_rd_req = (nxt_st.txs == TX_RUN) && (nxt_st.tx_len_cnt != 16'h0);

      // Receive memory-write stage; bytes past the buffer end are dropped
      if (st_ff.mem_wr_valid && mem_wr_ready_i) begin
         nxt_st.mem_wr_valid = 1'b0;
      end
      if (fifo_out_ready && fifo_out_valid) begin
         if (st_ff.rx_len_cnt != 16'h0) begin
            nxt_st.mem_wr_valid = 1'b1;
            nxt_st.mem_wr_addr  = st_ff.rx_addr_cnt;
            nxt_st.mem_wr_data  = fifo_out_data;
            nxt_st.rx_addr_cnt  = st_ff.rx_addr_cnt + 32'h1;
            nxt_st.rx_len_cnt   = st_ff.rx_len_cnt - 16'h1;
         end
      end

      // Receive engine
      is_bcast   = (st_ff.dst == {6{8'hFF}});
      is_station = (st_ff.dst == st_ff.station_address_bytes);
      case (st_ff.receive_mask_reg[7:6])
         FILT_ALL:     accepted = 1'b1;
         FILT_STATION: accepted = is_bcast || is_station;
         FILT_MULTI:   accepted = is_bcast || is_station || st_ff.dst[0][0];
         default:      accepted = 1'b0;
      endcase
      runt = (st_ff.nbytes < RUNT_LIMIT);
      rres[RX_RUNT_BIT] = runt;
      rres[RX_ODD_BIT]  = rx_odd_bit_tail_i;
      rres[RX_CRC_BIT]  = rx_checksum_fail_i;
      rres[RX_OVF_BIT]  = st_ff.ovf;
      rres[RX_SEEN_BIT] = !st_ff.ovf;
      rres[RX_GOOD_BIT] = !runt && !st_ff.ovf && !rx_checksum_fail_i;

      case (st_ff.rxs)
         RX_IDLE: begin
            if (rx_enable_i && !st_ff.desc_empty) begin
               nxt_st.rx_addr_cnt = {st_ff.dq_base[slot], 2'b00};
               nxt_st.rx_len_cnt  = {st_ff.dq_size[slot], 4'h0};
               nxt_st.rxs         = RX_READY;
            end
         end
         RX_READY: begin
            if (rx_byte_valid_i) begin
               nxt_st.dst[0] = rx_byte_i;
               nxt_st.nbytes = 16'h1;
               nxt_st.ovf    = fifo_in_valid && !fifo_in_ready;
               nxt_st.rxs    = RX_FRAME;
            end else if (!rx_enable_i) begin
               nxt_st.rxs = RX_IDLE;
            end
         end
         RX_FRAME: begin
            if (rx_frame_end_i) begin
               // Status only changes for a kept good packet or an error
               if ((rres[RX_GOOD_BIT] && accepted) || ((rres & RX_ERR_EVENTS) != 6'h0)) begin
                  nxt_st.receive_result_reg = rres;
               end
               nxt_st.rx_keep   = rres[RX_GOOD_BIT] && accepted;
               nxt_st.rx_stop   = ((rres & RX_ERR_EVENTS & st_ff.receive_mask_reg[5:0]) != 6'h0);
               nxt_st.rx_notify = st_ff.receive_mask_reg[RX_GOOD_BIT];
               nxt_st.rxs       = RX_DRAIN;
            end else if (rx_byte_valid_i) begin
               if (st_ff.nbytes < 16'h6) begin
                  nxt_st.dst[st_ff.nbytes[2:0]] = rx_byte_i;
               end
               if (st_ff.nbytes != 16'hFFFF) begin
                  nxt_st.nbytes = st_ff.nbytes + 16'h1;
               end
               if (fifo_in_valid && !fifo_in_ready) begin
                  nxt_st.ovf = 1'b1;
               end
            end
         end
         RX_DRAIN: begin
            // Wait until every byte of the frame has reached memory
            if (!fifo_out_valid && !st_ff.mem_wr_valid) begin
               if (st_ff.rx_stop) begin
                  nxt_st.rx_irq = 1'b1;
                  nxt_st.rxs    = RX_HALT;
               end else if (st_ff.rx_keep) begin
                  nxt_st.descriptor_consume_ptr = st_ff.descriptor_consume_ptr + 4'h1;
                  nxt_st.rx_irq = nxt_st.rx_irq || st_ff.rx_notify;
                  nxt_st.rxs    = RX_IDLE;
               end else begin
                  nxt_st.rx_addr_cnt = {st_ff.dq_base[slot], 2'b00};
                  nxt_st.rx_len_cnt  = {st_ff.dq_size[slot], 4'h0};
                  nxt_st.rxs         = RX_READY;
               end
            end
         end
         default: begin
            if (!rx_enable_i) begin
               nxt_st.rx_addr_cnt = {st_ff.dq_base[slot], 2'b00};
               nxt_st.rx_len_cnt  = {st_ff.dq_size[slot], 4'h0};
               nxt_st.rxs         = RX_IDLE;
            end
         end
      endcase

      // Board copies follow any raised interrupt or any status read
      if (status_rd || (nxt_st.tx_irq && !st_ff.tx_irq) || (nxt_st.rx_irq && !st_ff.rx_irq)) begin
         nxt_st.send_copy = {4'h0, nxt_st.send_result_reg};
         nxt_st.recv_copy = {2'b00, nxt_st.receive_result_reg};
      end

      nxt_st.desc_empty = (nxt_st.descriptor_produce_ptr == nxt_st.descriptor_consume_ptr);
      nxt_st.desc_full  = ((nxt_st.descriptor_produce_ptr + 4'h1) ==
                           nxt_st.descriptor_consume_ptr);
   end

   always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         st_ff                  <= '0;
         st_ff.receive_mask_reg <= RX_MASK_RST;
         st_ff.send_mask_reg    <= TX_MASK_RST;
         st_ff.txs              <= TX_IDLE;
         st_ff.rxs              <= RX_IDLE;
         st_ff.desc_empty       <= 1'b1;
      end else begin
         st_ff <= nxt_st;
      end
   end

   assign io_ack_o                 = st_ff.io_ack;
   assign io_rdata_o               = st_ff.io_rdata;
   assign tx_rd_req_o              = st_ff.tx_rd_req;
   assign tx_rd_addr_o             = st_ff.tx_addr_cnt;
   assign mem_wr_valid_o           = st_ff.mem_wr_valid;
   assign mem_wr_addr_o            = st_ff.mem_wr_addr;
   assign mem_wr_data_o            = st_ff.mem_wr_data;
   assign tx_irq_o                 = st_ff.tx_irq;
   assign rx_irq_o                 = st_ff.rx_irq;
   assign send_result_copy_o       = st_ff.send_copy;
   assign receive_result_copy_o    = st_ff.recv_copy;
   assign descriptor_consume_ptr_o = st_ff.descriptor_consume_ptr;
   assign descriptor_produce_ptr_o = st_ff.descriptor_produce_ptr;
   assign desc_empty_o             = st_ff.desc_empty;
   assign desc_full_o              = st_ff.desc_full;
endmodule : emdp_top

`default_nettype wire

// File: shared/emdp_pkg.sv
/*
 * Shared constants for the network adaptor's MAC and DMA port: I/O group
 * selects, register offsets, status bit positions, reset values and sizes.
 * Assumes a 9-bit I/O address whose bits 8-6 pick a register group.
 */
`default_nettype none

package emdp_pkg;

   // I/O address layout
   localparam int unsigned GRP_HI         = 8;
   localparam int unsigned GRP_LO         = 6;
   localparam logic [2:0]  GRP_MAC        = 3'h2;
   localparam logic [2:0]  GRP_DMA        = 3'h1;

   // MAC controller register offsets (address bits 2-0)
   localparam logic [2:0]  OFS_STATION_LAST = 3'h5;
   localparam logic [2:0]  OFS_RX_MASK      = 3'h6;
   localparam logic [2:0]  OFS_TX_MASK      = 3'h7;

   // DMA register offsets (address bits 1-0)
   localparam logic [1:0]  OFS_TX_BASE    = 2'h0;
   localparam logic [1:0]  OFS_TX_SIZE    = 2'h1;
   localparam logic [1:0]  OFS_RX_BASE    = 2'h2;
   localparam logic [1:0]  OFS_RX_SIZE    = 2'h3;

   // Send mask / result bit positions
   localparam int unsigned TX_GOOD_BIT    = 3;
   localparam int unsigned TX_XCOL_BIT    = 2;
   localparam int unsigned TX_COL_BIT     = 1;
   localparam int unsigned TX_UF_BIT      = 0;

   // Receive mask / result bit positions
   localparam int unsigned RX_GOOD_BIT    = 5;
   localparam int unsigned RX_SEEN_BIT    = 4;
   localparam int unsigned RX_RUNT_BIT    = 3;
   localparam int unsigned RX_ODD_BIT     = 2;
   localparam int unsigned RX_CRC_BIT     = 1;
   localparam int unsigned RX_OVF_BIT     = 0;
   localparam logic [5:0]  RX_ERR_EVENTS  = 6'h0B;

   // Accept filter modes (receive mask bits 7-6)
   localparam logic [1:0]  FILT_NONE      = 2'h0;
   localparam logic [1:0]  FILT_ALL       = 2'h1;
   localparam logic [1:0]  FILT_STATION   = 2'h2;
   localparam logic [1:0]  FILT_MULTI     = 2'h3;

   // Reset values of the mask registers
   localparam logic [7:0]  RX_MASK_RST    = 8'h00;
   localparam logic [3:0]  TX_MASK_RST    = 4'h0;

   // Sizes and counts
   localparam logic [15:0] RUNT_LIMIT     = 16'h003C;
   localparam logic [15:0] TX_WORD_BYTES  = 16'h0004;
   localparam int unsigned DESC_DEPTH     = 16;
   localparam int unsigned FIFO_DEPTH     = 32;
   localparam int unsigned FIFO_WIDTH     = 8;

endpackage : emdp_pkg

`default_nettype wire

// File: testbench/emdp_asserts.sv
/* Port checker for emdp_top. Assumes the single clock and async low reset. */
`timescale 1ns/10ps
`default_nettype none
module emdp_asserts
   import emdp_pkg::*;
(
   input wire logic        clk_i, nrst_i, io_req_i, io_we_i, io_ack_o,
   input wire logic [8:0]  io_addr_i,
   input wire logic [31:0] io_rdata_o, tx_rd_addr_o,
   input wire logic        tx_rd_req_o, tx_rd_ack_i, tx_enable_i, tx_attempt_done_i,
   input wire logic [3:0]  descriptor_consume_ptr_o, descriptor_produce_ptr_o,
   input wire logic        desc_empty_o, desc_full_o
);
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!nrst_i);
   wire logic grp_ok = io_addr_i[8:6] == GRP_MAC || io_addr_i[8:6] == GRP_DMA;
   sequence s_size_wr;
      io_req_i && io_we_i && io_addr_i[8:6] == GRP_DMA && io_addr_i[1:0] == OFS_RX_SIZE;
   endsequence
   a_ack_follows: assert property (io_req_i && grp_ok |=> io_ack_o)
      else $error("missing ack");
   a_ack_cause: assert property (io_ack_o |-> $past(io_req_i && grp_ok))
      else $error("stray ack");
   a_rdata_idle: assert property (!io_ack_o |-> io_rdata_o == 32'h0)
      else $error("read data outside ack");
   a_empty_ptrs: assert property (desc_empty_o ==
      (descriptor_consume_ptr_o == descriptor_produce_ptr_o)) else $error("empty flag");
   a_full_ptrs: assert property (desc_full_o ==
      (descriptor_produce_ptr_o + 4'h1 == descriptor_consume_ptr_o)) else $error("full flag");
   a_produce_step: assert property (s_size_wr ##0 !desc_full_o |=>
      descriptor_produce_ptr_o == $past(descriptor_produce_ptr_o) + 4'h1)
      else $error("producer step");
   a_consume_step: assert property ($changed(descriptor_consume_ptr_o) |->
      descriptor_consume_ptr_o == $past(descriptor_consume_ptr_o) + 4'h1)
      else $error("consumer step");
   a_send_addr_step: assert property (tx_rd_req_o && tx_rd_ack_i && tx_enable_i
      && !tx_attempt_done_i |=> tx_rd_addr_o == $past(tx_rd_addr_o) + 32'h4)
      else $error("send address step");
   a_result_width: assert property (io_req_i && !io_we_i && io_addr_i == 9'h087
      |=> io_rdata_o[31:4] == 28'h0) else $error("send result upper bits");
endmodule : emdp_asserts
`default_nettype wire
bind emdp_top emdp_asserts i_chk (.clk_i, .nrst_i, .io_req_i, .io_we_i, .io_ack_o,
   .io_addr_i, .io_rdata_o, .tx_rd_addr_o, .tx_rd_req_o, .tx_rd_ack_i, .tx_enable_i,
   .tx_attempt_done_i, .descriptor_consume_ptr_o, .descriptor_produce_ptr_o,
   .desc_empty_o, .desc_full_o);

// File: testbench/emdp_mac_model.sv
/* MAC side model: memory read acks, stalling write sink, byte frames.
   Assumes the bench calls send() from its main sequence. */
`timescale 1ns/10ps
`default_nettype none
module emdp_mac_model (
   input wire logic        clk_i, rd_req_i, wr_valid_i,
   input wire logic [31:0] wr_addr_i,
   input wire logic [7:0]  wr_data_i,
   output logic            rd_ack_o, wr_ready_o, byte_valid_o, frame_end_o,
   output logic [7:0]      byte_o
);
   logic [31:0] last_addr = 32'h0;
   logic [7:0]  last_data = 8'h0;
   initial {rd_ack_o, wr_ready_o, byte_valid_o, frame_end_o, byte_o} = 12'h0;
   always @(posedge clk_i) begin
      if (wr_valid_i && wr_ready_o) {last_addr, last_data} = {wr_addr_i, wr_data_i};
      #1 wr_ready_o = ~wr_ready_o;
      rd_ack_o = rd_req_i && !rd_ack_o;
   end
   // One byte every third cycle so the drain side keeps up
   task automatic send(input int n, input logic [7:0] dst);
      for (int i = 0; i < n; i++) begin
         @(posedge clk_i) #1 byte_valid_o = 1'b1;
         byte_o = (i < 6) ? dst : i[7:0];
         @(posedge clk_i) #1 byte_valid_o = 1'b0;
         byte_o = ~byte_o;
         @(posedge clk_i);
      end
      #1 frame_end_o = 1'b1;
      @(posedge clk_i) #1 frame_end_o = 1'b0;
   endtask : send
endmodule : emdp_mac_model
`default_nettype wire

// File: testbench/emdp_top_tb.sv
/* Bench for emdp_top: I/O register tasks, MAC model, checker by bind. */
`timescale 1ns/10ps
`default_nettype none
`define CHK(n, e, g) begin total_checks++; if ((g) !== (e)) begin mismatches++; \
   $display("Error %s exp %0h got %0h", n, e, g); end end
module emdp_top_tb;
   logic clk_i = 0, nrst_i = 0, io_req_i = 0, io_we_i = 0, ak, tx_enable_i = 0;
   logic rx_enable_i = 0, tx_attempt_done_i = 0, tx_collision_i = 0;
   logic tx_excess_collision_i = 0, tx_underflow_i = 0, bad = 0;
   logic [8:0] io_addr_i = 0;
   logic [31:0] io_wdata_i = 0, rd;
   int mismatches = 0, total_checks = 0;
   wire logic io_ack_o, tx_rd_req_o, tx_rd_ack_i, rx_byte_valid_i, rx_frame_end_i;
   wire logic mem_wr_valid_o, mem_wr_ready_i, tx_irq_o, rx_irq_o, desc_empty_o, desc_full_o;
   wire logic [31:0] io_rdata_o, tx_rd_addr_o, mem_wr_addr_o;
   wire logic [7:0] rx_byte_i, mem_wr_data_o, send_result_copy_o, receive_result_copy_o;
   wire logic [3:0] descriptor_consume_ptr_o, descriptor_produce_ptr_o;
   logic [2:0] evs [3] = '{3'b000, 3'b100, 3'b001};
   logic [7:0] res [3] = '{8'h08, 8'h04, 8'h01};
   emdp_top i_dut (.*, .rx_checksum_fail_i(bad), .rx_odd_bit_tail_i(bad));
   emdp_mac_model i_mac (.clk_i, .rd_req_i(tx_rd_req_o), .wr_valid_i(mem_wr_valid_o),
      .wr_data_i(mem_wr_data_o),
      .wr_addr_i(mem_wr_addr_o), .rd_ack_o(tx_rd_ack_i), .wr_ready_o(mem_wr_ready_i),
      .byte_valid_o(rx_byte_valid_i), .frame_end_o(rx_frame_end_i), .byte_o(rx_byte_i));
   always #2 clk_i = ~clk_i;
   task automatic io(input logic we, input logic [8:0] a, input logic [31:0] d);
      @(posedge clk_i) #1 {io_req_i, io_we_i, io_addr_i, io_wdata_i} = {1'b1, we, a, d};
      @(posedge clk_i) #1 io_req_i = 1'b0;
      {ak, rd} = {io_ack_o, io_rdata_o};
   endtask : io
   task automatic rdc(input logic [8:0] a, input logic [31:0] e);
      io(1'b0, a, 32'h0);
      `CHK("ack", 1'b1, ak)
      `CHK("rdata", e, rd)
   endtask : rdc
   task automatic att(input logic [2:0] e);
      @(posedge clk_i) #1 tx_attempt_done_i = 1'b1;
      {tx_excess_collision_i, tx_collision_i, tx_underflow_i} = e;
      @(posedge clk_i) #1 tx_attempt_done_i = 1'b0;
   endtask : att
   task automatic stop_test();
      $display("Checks %0d mismatches %0d", total_checks, mismatches);
      if (mismatches == 0 && total_checks > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask : stop_test
   initial begin
      #100000 mismatches++;
      stop_test();
   end
   initial begin
      repeat (16) @(posedge clk_i);
      #1 nrst_i = 1'b1;
      `CHK("empty", 1'b1, desc_empty_o)
      for (int i = 0; i < 6; i++) io(1'b1, 9'h080 + 9'(i), 32'h10 + i);
      rdc(9'h087, 32'h0);
      rdc(9'h086, 32'h0);
      rdc(9'h080, 32'h0);
      io(1'b0, 9'h0C0, 32'h0);
      `CHK("unmapped", 1'b0, ak)
      io(1'b1, 9'h087, 32'hD);
      io(1'b1, 9'h086, 32'hA0);
      io(1'b1, 9'h040, 32'h103);
      io(1'b1, 9'h041, 32'h8);
      tx_enable_i = 1'b1;
      repeat (20) @(posedge clk_i);
      rdc(9'h040, 32'h108);
      att(3'b010);
      `CHK("reload", 32'h100, tx_rd_addr_o)
      `CHK("coll irq", 1'b0, tx_irq_o)
      for (int k = 0; k < 3; k++) begin
         att(evs[k]);
         `CHK("tx irq", 1'b1, tx_irq_o)
         `CHK("tx copy", res[k], send_result_copy_o)
         rdc(9'h087, {24'h0, res[k]});
         `CHK("tx clr", 1'b0, tx_irq_o)
         tx_enable_i = 1'b0;
         @(posedge clk_i) #1 tx_enable_i = 1'b1;
      end
      io(1'b1, 9'h087, 32'h2);
      att(3'b101);
      `CHK("retry", 32'h100, tx_rd_addr_o)
      `CHK("retry irq", 1'b0, tx_irq_o)
      att(3'b010);
      `CHK("coll stop", 1'b1, tx_irq_o)
      rdc(9'h087, 32'h2);
      io(1'b1, 9'h042, 32'h2000);
      io(1'b1, 9'h043, 32'h40);
      io(1'b1, 9'h042, 32'h3000);
      io(1'b1, 9'h043, 32'h40);
      `CHK("produce", 4'h2, descriptor_produce_ptr_o)
      rx_enable_i = 1'b1;
      i_mac.send(64, 8'hFF);
      for (int k = 0; k < 500 && descriptor_consume_ptr_o !== 4'h1; k++) @(posedge clk_i);
      @(posedge clk_i) #1;
      `CHK("consume", 4'h1, descriptor_consume_ptr_o)
      `CHK("rx irq", 1'b1, rx_irq_o)
      `CHK("last byte", 32'h203F, i_mac.last_addr)
      `CHK("last data", 8'h3F, i_mac.last_data)
      rdc(9'h086, 32'h30);
      `CHK("rx copy", 8'h30, receive_result_copy_o)
      i_mac.send(20, 8'hFF);
      repeat (100) @(posedge clk_i);
      `CHK("runt irq", 1'b0, rx_irq_o)
      rdc(9'h086, 32'h18);
      rdc(9'h042, 32'h3000);
      io(1'b1, 9'h086, 32'hA2);
      bad = 1'b1;
      i_mac.send(64, 8'hFF);
      repeat (100) @(posedge clk_i);
      `CHK("crc irq", 1'b1, rx_irq_o)
      `CHK("crc copy", 8'h16, receive_result_copy_o)
      rdc(9'h086, 32'h16);
      bad = 1'b0;
      for (int i = 0; i < 14; i++) begin
         io(1'b1, 9'h042, 32'h4000);
         io(1'b1, 9'h043, 32'h10);
      end
      `CHK("full", 1'b1, desc_full_o)
      io(1'b1, 9'h043, 32'h10);
      `CHK("ignored", 4'h0, descriptor_produce_ptr_o)
      stop_test();
   end
endmodule : emdp_top_tb
`default_nettype wire
